/* core/rch_pkg.sv */
// Shared constants and types of the receive channel-hop sequencer.
package rch_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int RSSI_SETTLE_NS = 1000;
  localparam int RSSI_SETTLE_CYC = (RSSI_SETTLE_NS * CLK_MHZ + 999) / 1000;

  // ---------------------------------------------------------------
  // Table layout
  // ---------------------------------------------------------------
  localparam int TABLE_DEPTH = 64;
  localparam logic [7:0] EMPTY_SLOT = 8'h_ff;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [9:0] OFS_CTRL = 10'h_000;
  localparam logic [9:0] OFS_TABLE_SIZE = 10'h_004;
  localparam logic [9:0] OFS_RSSI_THR = 10'h_008;
  localparam logic [9:0] OFS_BASE_FREQ = 10'h_00c;
  localparam logic [9:0] OFS_STEP = 10'h_010;
  localparam logic [9:0] OFS_PRE_THR = 10'h_014;
  localparam logic [9:0] OFS_PRE_WAIT = 10'h_018;
  localparam logic [9:0] OFS_CMD_START = 10'h_01c;
  localparam logic [9:0] OFS_CMD_STOP = 10'h_020;
  localparam logic [9:0] OFS_CMD_MANUAL = 10'h_024;
  localparam logic [9:0] OFS_STATUS = 10'h_028;
  localparam logic [1:0] OFS_TABLE_PAGE = 2'b01;

  // ---------------------------------------------------------------
  // Control fields and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_RSSI = 1;
  localparam int CTRL_PRE = 2;
  localparam int CTRL_SYNC = 3;
  localparam int CTRL_RAW = 4;
  localparam int CTRL_GPIO = 5;
  localparam int MANUAL_OSC_LSB = 16;
  localparam logic [5:0] RST_CTRL = 6'h_00;
  localparam logic [7:0] RST_SIZE = 8'h_00;
  localparam logic [7:0] RST_THR = 8'h_00;
  localparam logic [31:0] RST_BASE = 32'h_0000_0000;
  localparam logic [15:0] RST_STEP = 16'h_0000;
  localparam logic [7:0] RST_PRE = 8'h_00;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle,
    st_fetch,
    st_check,
    st_dwell,
    st_stay,
    st_manual
  } rch_fsm_t;

endpackage : rch_pkg

/* core/rch_table_mem.sv */
// Channel table storage with one write port and two registered read ports.
`timescale 1ns/1ns
module rch_table_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] a_addr,
  output logic [WIDTH-1:0] a_data,
  input wire logic [$clog2(DEPTH)-1:0] b_addr,
  output logic [WIDTH-1:0] b_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("rch_table_mem: unsupported size");
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    a_data <= mem[a_addr];
    b_data <= mem[b_addr];
  end

endmodule : rch_table_mem

/* core/rch_hop_seq.sv */
// Receive channel-hop sequencer with its register port.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module rch_hop_seq
  import rch_pkg::*;
#(
  parameter int DEPTH = TABLE_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [9:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [7:0] rssi_now,
  input wire logic preamble_valid,
  input wire logic preamble_timeout,
  input wire logic sync_ok,
  input wire logic sync_timeout,
  output logic rx_active,
  output logic [7:0] rf_channel,
  output logic [31:0] rf_freq,
  output logic tune_strobe,
  output logic use_host_cal,
  output logic [15:0] oscillator_count_value,
  output logic [7:0] signal_level_threshold,
  output logic [7:0] preamble_detect_threshold,
  output logic [7:0] preamble_wait_limit,
  output logic hop_gpio
);

  localparam int IW = $clog2(DEPTH);
  localparam logic [7:0] DEPTH_B = 8'(DEPTH);
  localparam logic [15:0] SETTLE_B = 16'(RSSI_SETTLE_CYC);

  initial begin
    // The table page holds 64 word slots, so a deeper table could not be reached.
    if (DEPTH < 2 || DEPTH > 64 || (1 << IW) != DEPTH) begin
      $error("rch_hop_seq: DEPTH must be a power of two from 2 to 64");
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    rch_fsm_t fsm;
    logic [IW-1:0] idx;
    logic [7:0] scanned;
    logic [15:0] settle;
    logic [7:0] chan;
    logic [31:0] freq;
    logic tune;
    logic gpio;
    logic active;
    logic host_cal;
    logic [15:0] osc;
    logic [5:0] ctrl;
    logic [7:0] size;
    logic [7:0] thr;
    logic [31:0] base;
    logic [15:0] step;
    logic [7:0] pre_thr;
    logic [7:0] pre_wait;
    logic [31:0] rdata;
    logic tbl_rd;
  } rch_state_t;

  rch_state_t st;
  rch_state_t next_st;

  logic [7:0] mem_a;
  logic [7:0] mem_b;
  logic tbl_hit;
  logic [7:0] eff_size;
  logic [IW:0] adv;
  logic stay_now;
  logic hop_now;

  function automatic logic [31:0] calc_freq(input logic [31:0] base, input logic [15:0] step,
                                            input logic [7:0] ch);
    logic [23:0] prod;
    prod = ch * step;
    calc_freq = base + {8'h_00, prod};
  endfunction : calc_freq

  // Returns the wrap flag above the next position.
  function automatic logic [IW:0] next_pos(input logic [IW-1:0] idx, input logic [7:0] size);
    logic [7:0] nxt;
    nxt = 8'(idx) + 8'h_01;
    if (nxt >= size) begin
      next_pos = {1'b1, {IW{1'b0}}};
    end else begin
      next_pos = {1'b0, nxt[IW-1:0]};
    end
  endfunction : next_pos

  // Compared one bit wider so that a full 64-entry table is not cut to zero.
  assign tbl_hit = (reg_addr[9:8] == OFS_TABLE_PAGE) && ({1'b0, reg_addr[7:2]} < 7'(DEPTH));

  rch_table_mem #(
    .WIDTH(8),
    .DEPTH(DEPTH)
  ) u_mem (
    .ref_clk(ref_clk),
    .wr_en(reg_wr && tbl_hit),
    .wr_addr(reg_addr[IW+1:2]),
    .wr_data(reg_wdata[7:0]),
    .a_addr(st.idx),
    .a_data(mem_a),
    .b_addr(reg_addr[IW+1:2]),
    .b_data(mem_b)
  );

  // Sizes above the table depth are clamped so the walk never leaves the table.
  assign eff_size = (st.size > DEPTH_B) ? DEPTH_B : st.size;
  assign adv = next_pos(st.idx, eff_size);

  // ---------------------------------------------------------------
  // Qualifier decision
  // ---------------------------------------------------------------
  // Packet qualifiers are masked in raw mode because those events are meaningless there.
  always_comb begin
    logic pre_en;
    logic sync_en;
    logic rssi_due;
    pre_en = st.ctrl[CTRL_PRE] && !st.ctrl[CTRL_RAW];
    sync_en = st.ctrl[CTRL_SYNC] && !st.ctrl[CTRL_RAW];
    rssi_due = st.ctrl[CTRL_RSSI] && (st.settle == SETTLE_B);
    stay_now = 1'b0;
    hop_now = 1'b0;
    // A packet stay and a timeout hop in one cycle resolve as stay, since a found packet is worth more; a timeout beats the RSSI decision.
    if (sync_en && sync_ok) begin
      stay_now = 1'b1;
    end else if (pre_en && !sync_en && preamble_valid) begin
      stay_now = 1'b1;
    end else if ((sync_en && sync_timeout) || (pre_en && preamble_timeout)) begin
      hop_now = 1'b1;
    end else if (rssi_due) begin
      stay_now = (rssi_now > st.thr);
      hop_now = !(rssi_now > st.thr);
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.tune = 1'b0;
    next_st.rdata = 32'h_0000_0000;
    next_st.tbl_rd = reg_rd && tbl_hit;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL: next_st.rdata = {26'h_000_0000, st.ctrl};
        OFS_TABLE_SIZE: next_st.rdata = {24'h_00_0000, st.size};
        OFS_RSSI_THR: next_st.rdata = {24'h_00_0000, st.thr};
        OFS_BASE_FREQ: next_st.rdata = st.base;
        OFS_STEP: next_st.rdata = {16'h_0000, st.step};
        OFS_PRE_THR: next_st.rdata = {24'h_00_0000, st.pre_thr};
        OFS_PRE_WAIT: next_st.rdata = {24'h_00_0000, st.pre_wait};
        OFS_STATUS: begin
          next_st.rdata = {8'h_00, st.chan, 8'(st.idx), 4'h_0, st.host_cal,
                           st.fsm == st_stay, st.active, st.gpio};
        end
        default: next_st.rdata = 32'h_0000_0000;
      endcase
    end
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CTRL: next_st.ctrl = reg_wdata[5:0];
        OFS_TABLE_SIZE: next_st.size = reg_wdata[7:0];
        OFS_RSSI_THR: next_st.thr = reg_wdata[7:0];
        OFS_BASE_FREQ: next_st.base = reg_wdata;
        OFS_STEP: next_st.step = reg_wdata[15:0];
        OFS_PRE_THR: next_st.pre_thr = reg_wdata[7:0];
        OFS_PRE_WAIT: next_st.pre_wait = reg_wdata[7:0];
        default: next_st.ctrl = st.ctrl;
      endcase
    end
    unique case (st.fsm)
      st_idle: next_st.fsm = st_idle;
      st_fetch: next_st.fsm = st_check;
      st_check: begin
        if (mem_a != EMPTY_SLOT) begin
          next_st.chan = mem_a;
          next_st.freq = calc_freq(st.base, st.step, mem_a);
          next_st.tune = 1'b1;
          next_st.gpio = st.gpio ^ st.ctrl[CTRL_GPIO];
          next_st.settle = 16'h_0000;
          next_st.scanned = 8'h_00;
          next_st.fsm = st_dwell;
        end else if (st.scanned + 8'h_01 >= eff_size) begin
          next_st.fsm = st_stay;
        end else begin
          next_st.scanned = st.scanned + 8'h_01;
          next_st.idx = adv[IW-1:0];
          next_st.gpio = st.gpio ^ (st.ctrl[CTRL_GPIO] & adv[IW]);
          next_st.fsm = st_fetch;
        end
      end
      st_dwell: begin
        if (st.settle != SETTLE_B) begin
          next_st.settle = st.settle + 16'h_0001;
        end
        if (stay_now) begin
          next_st.fsm = st_stay;
        end else if (hop_now) begin
          next_st.idx = adv[IW-1:0];
          next_st.gpio = st.gpio ^ (st.ctrl[CTRL_GPIO] & adv[IW]);
          next_st.scanned = 8'h_00;
          next_st.fsm = st_fetch;
        end
      end
      st_stay: next_st.fsm = st_stay;
      st_manual: next_st.fsm = st_manual;
    endcase
    // Commands override the walk so software can always regain control.
    if (reg_wr && reg_addr == OFS_CMD_START) begin
      next_st.active = 1'b1;
      next_st.host_cal = 1'b0;
      next_st.chan = reg_wdata[7:0];
      next_st.freq = calc_freq(st.base, st.step, reg_wdata[7:0]);
      next_st.tune = 1'b1;
      next_st.idx = {IW{1'b0}};
      next_st.scanned = 8'h_00;
      next_st.settle = 16'h_0000;
      // An empty table leaves the receiver parked on the start channel.
      if (st.ctrl[CTRL_AUTO] && eff_size != 8'h_00) begin
        next_st.fsm = st_fetch;
      end else begin
        next_st.fsm = st_stay;
      end
    end else if (reg_wr && reg_addr == OFS_CMD_MANUAL) begin
      next_st.active = 1'b1;
      next_st.host_cal = 1'b1;
      next_st.osc = reg_wdata[MANUAL_OSC_LSB +: 16];
      next_st.chan = reg_wdata[7:0];
      next_st.freq = calc_freq(st.base, st.step, reg_wdata[7:0]);
      next_st.tune = 1'b1;
      next_st.fsm = st_manual;
    end else if (reg_wr && reg_addr == OFS_CMD_STOP) begin
      next_st.active = 1'b0;
      next_st.fsm = st_idle;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
      st.fsm <= st_idle;
      st.ctrl <= RST_CTRL;
      st.size <= RST_SIZE;
      st.thr <= RST_THR;
      st.base <= RST_BASE;
      st.step <= RST_STEP;
      st.pre_thr <= RST_PRE;
      st.pre_wait <= RST_PRE;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata = st.tbl_rd ? {24'h_00_0000, mem_b} : st.rdata;
  assign rx_active = st.active;
  assign rf_channel = st.chan;
  assign rf_freq = st.freq;
  assign tune_strobe = st.tune;
  assign use_host_cal = st.host_cal;
  assign oscillator_count_value = st.osc;
  assign signal_level_threshold = st.thr;
  assign preamble_detect_threshold = st.pre_thr;
  assign preamble_wait_limit = st.pre_wait;
  assign hop_gpio = st.gpio;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_start_auto;
    reg_wr && reg_addr == OFS_CMD_START && st.ctrl[CTRL_AUTO] && eff_size != 8'h_00;
  endsequence
  sequence s_walk_begins;
    st.fsm == st_fetch && st.idx == '0 ##1 st.fsm == st_check;
  endsequence
  sequence s_plain_dwell;
    st.fsm == st_dwell && !reg_wr;
  endsequence

  a_start_walks: assert property (s_start_auto |=> s_walk_begins)
    else $error("walk did not begin at position zero");
  a_empty_skipped: assert property (st.fsm == st_check && mem_a == EMPTY_SLOT && !reg_wr
    |=> !tune_strobe && st.fsm != st_dwell)
    else $error("empty slot was tuned");
  a_entry_tuned: assert property (st.fsm == st_check && mem_a != EMPTY_SLOT && !reg_wr
    |=> tune_strobe && rf_channel == $past(mem_a) && st.fsm == st_dwell)
    else $error("valid slot not tuned");
  a_freq_formula: assert property (tune_strobe
    |-> rf_freq == st.base + {8'h_00, 24'(rf_channel * st.step)})
    else $error("frequency mismatch");
  a_rssi_stay: assert property (s_plain_dwell and (stay_now && !sync_ok && !preamble_valid)
    |=> st.fsm == st_stay)
    else $error("strong signal did not stay");
  a_hop_wraps: assert property (s_plain_dwell and (hop_now && st.idx == IW'(eff_size - 8'h_01))
    |=> st.idx == '0 && st.fsm == st_fetch)
    else $error("walk did not wrap");
  a_raw_ignores: assert property (s_plain_dwell and (st.ctrl[CTRL_RAW] && !st.ctrl[CTRL_RSSI])
    |=> st.fsm == st_dwell)
    else $error("raw mode acted on packet qualifier");
  a_hop_toggles: assert property (tune_strobe && !$past(reg_wr) && st.ctrl[CTRL_GPIO]
    |-> hop_gpio != $past(hop_gpio))
    else $error("gpio did not toggle on hop");
  a_all_empty: assert property (st.fsm == st_check && mem_a == EMPTY_SLOT && !reg_wr
    && st.scanned + 8'h_01 >= eff_size |=> st.fsm == st_stay [*2])
    else $error("all-empty table kept searching");
  a_manual_cal: assert property (reg_wr && reg_addr == OFS_CMD_MANUAL
    |=> use_host_cal && oscillator_count_value == $past(reg_wdata[31:16]))
    else $error("host calibration value not used");

endmodule : rch_hop_seq

/* dv/rch_host_model.sv */
// Host-side model that programs the hop sequencer over its register port.
`timescale 1ns/1ns
module rch_host_model
  import rch_pkg::*;
(
  input wire logic ref_clk,
  output logic [9:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr = 10'h_000;
    reg_wdata = 32'h_0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd

  // ---------------------------------------------------------------
  // Configuration and commands
  // ---------------------------------------------------------------
  // Everything is programmed before the start command, so the walk never sees a half table.
  task automatic setup(input logic [31:0] base, input logic [15:0] step,
                       input logic [7:0] thr, input logic [31:0] ctrl, input logic [7:0] tbl[$]);
    logic [7:0] first;
    first = 8'h_07;
    wr(OFS_BASE_FREQ, base);
    wr(OFS_STEP, {16'h_0000, step});
    wr(OFS_TABLE_SIZE, 32'(tbl.size()));
    for (int i = tbl.size() - 1; i >= 0; i--) begin
      wr({OFS_TABLE_PAGE, 6'(i), 2'b00}, {24'h_0000_00, tbl[i]});
      if (tbl[i] != EMPTY_SLOT) begin
        first = tbl[i];
      end
    end
    wr(OFS_RSSI_THR, {24'h_0000_00, thr});
    wr(OFS_PRE_THR, 32'h_0000_0003);
    wr(OFS_PRE_WAIT, 32'h_0000_0010);
    wr(OFS_CTRL, ctrl);
    wr(OFS_CMD_START, {24'h_0000_00, first});
  endtask : setup

  task automatic manual(input logic [7:0] ch, input logic [15:0] osc);
    wr(OFS_CMD_MANUAL, {osc, 8'h_00, ch});
  endtask : manual
endmodule : rch_host_model

/* dv/testbench.sv */
// Self-checking bench of the receive channel-hop sequencer.
`timescale 1ns/1ns
`define CHK(act, exp) begin n_checks++; if ((act) !== (exp)) begin n_mismatch++; \
  $display("ERROR %0t mismatch got %0h expected %0h", $time, act, exp); end end
module testbench;
  import rch_pkg::*;
  localparam logic [31:0] BASE = 32'h_3600_0000;
  localparam logic [15:0] STEP = 16'h_0190;
  localparam logic [31:0] K_AUTO = 32'(1) << CTRL_AUTO;
  localparam logic [31:0] K_RSSI = 32'(1) << CTRL_RSSI;
  localparam logic [31:0] K_PRE = 32'(1) << CTRL_PRE;
  localparam logic [31:0] K_SYNC = 32'(1) << CTRL_SYNC;
  localparam logic [31:0] K_RAW = 32'(1) << CTRL_RAW;
  localparam logic [31:0] K_GPIO = 32'(1) << CTRL_GPIO;
  logic ref_clk, rst, reg_wr, reg_rd, rx_active, tune_strobe, use_host_cal, hop_gpio, gpio_prev;
  logic preamble_valid, preamble_timeout, sync_ok, sync_timeout;
  logic [9:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rf_freq, rd_val;
  logic [7:0] rssi_now, rf_channel, slt, pdt, pwl;
  logic [15:0] oscillator_count_value;
  logic [7:0] tunes[$], tq[$];
  int togs[$];
  int n_mismatch, n_checks, n_toggle;

  rch_hop_seq dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rssi_now(rssi_now),
    .preamble_valid(preamble_valid), .preamble_timeout(preamble_timeout), .sync_ok(sync_ok),
    .sync_timeout(sync_timeout), .rx_active(rx_active), .rf_channel(rf_channel),
    .rf_freq(rf_freq), .tune_strobe(tune_strobe), .use_host_cal(use_host_cal),
    .oscillator_count_value(oscillator_count_value), .signal_level_threshold(slt),
    .preamble_detect_threshold(pdt), .preamble_wait_limit(pwl), .hop_gpio(hop_gpio));
  rch_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // Tune monitor
  // ---------------------------------------------------------------
  // Sampled at the falling edge so the registered outputs have settled.
  always @(negedge ref_clk) begin
    if (!rst && hop_gpio !== gpio_prev) n_toggle++;
    gpio_prev = hop_gpio;
    if (tune_strobe === 1'b1) begin
      tunes.push_back(rf_channel);
      togs.push_back(n_toggle);
      `CHK(rf_freq, BASE + 32'(rf_channel) * 32'(STEP))
    end
  end

  task automatic give_verdict();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic wait_tunes(input int n, input int lim);
    int k;
    k = 0;
    while (tunes.size() < n && k < lim) begin
      @(posedge ref_clk);
      k++;
    end
  endtask : wait_tunes

  task automatic pulse(input int ev);
    @(posedge ref_clk);
    preamble_valid <= (ev == 0);
    preamble_timeout <= (ev == 1);
    sync_ok <= (ev == 2);
    sync_timeout <= (ev == 3);
    @(posedge ref_clk);
    {preamble_valid, preamble_timeout, sync_ok, sync_timeout} <= 4'h_0;
  endtask : pulse

  task automatic run(input logic [31:0] ctrl, input logic [7:0] thr);
    host.wr(OFS_CMD_STOP, 32'h_0000_0000);
    tunes.delete();
    togs.delete();
    n_toggle = 0;
    host.setup(BASE, STEP, thr, ctrl, tq);
  endtask : run

  // One qualifier event on channel 6; a hop, where expected, must land on channel 8 within 150 cycles.
  task automatic qual_case(input logic [31:0] ctrl, input logic [7:0] lvl, input int ev,
                           input int hop);
    rssi_now <= lvl;
    tq = '{8'h_06, 8'h_08};
    run(ctrl, 8'h_20);
    wait_tunes(2, 12);
    `CHK(tunes.size(), 2)
    `CHK(tunes[1], 8'h_06)
    repeat (5) @(posedge ref_clk);
    pulse(ev);
    repeat (150) @(posedge ref_clk);
    `CHK(tunes.size(), 2 + hop)
    if (tunes.size() > 2) `CHK(tunes[2], 8'h_08)
  endtask : qual_case

  initial begin
    rst = 1'b1;
    rssi_now = 8'h_00;
    {preamble_valid, preamble_timeout, sync_ok, sync_timeout} = 4'h_0;
    gpio_prev = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    `CHK({rx_active, rf_channel, hop_gpio, use_host_cal}, 11'h_000)
    host.rd(OFS_CTRL, rd_val);
    `CHK(rd_val, 32'h_0000_0000)
    host.wr(OFS_RSSI_THR, 32'h_0000_005a);
    host.rd(OFS_RSSI_THR, rd_val);
    `CHK(rd_val, 32'h_0000_005a)
    `CHK(slt, 8'h_5a)
    host.wr(10'h_1fc, 32'h_0000_0033);
    host.rd(10'h_1fc, rd_val);
    `CHK(rd_val, 32'h_0000_0033)
    host.rd(10'h_3fc, rd_val);
    `CHK(rd_val, 32'h_0000_0000)
    // Strength walk with skip, wrap and pin toggles; level equal to threshold must hop.
    rssi_now <= 8'h_40;
    tq = '{8'h_05, 8'h_ff, 8'h_09, 8'h_0c};
    run(K_AUTO | K_RSSI | K_GPIO, 8'h_40);
    wait_tunes(6, 2000);
    `CHK(tunes.size(), 6)
    `CHK({tunes[1], tunes[2], tunes[3], tunes[4], tunes[5]}, 40'h_0509_0c05_09)
    `CHK(togs[5], 6)
    rssi_now <= 8'h_41;
    repeat (300) @(posedge ref_clk);
    `CHK(tunes.size(), 6)
    host.rd(OFS_STATUS, rd_val);
    `CHK({rd_val[23:16], rd_val[2]}, 9'h_013)
    `CHK({pdt, pwl}, 16'h_0310)
    // Qualifier combinations.
    qual_case(K_AUTO | K_PRE, 8'h_00, 1, 1);
    qual_case(K_AUTO | K_SYNC, 8'h_00, 3, 1);
    qual_case(K_AUTO | K_PRE | K_RAW, 8'h_00, 1, 0);
    qual_case(K_AUTO | K_SYNC | K_RSSI, 8'h_00, 2, 0);
    qual_case(K_AUTO | K_SYNC | K_RSSI, 8'h_ff, 3, 1);
    qual_case(K_AUTO | K_PRE | K_RSSI, 8'h_00, 0, 0);
    // A table of empty slots only parks on the start channel.
    rssi_now <= 8'h_00;
    tq = '{8'h_ff, 8'h_ff, 8'h_ff};
    run(K_AUTO | K_RSSI, 8'h_20);
    repeat (400) @(posedge ref_clk);
    `CHK({tunes.size(), rx_active}, {32'd1, 1'b1})
    host.manual(8'h_21, 16'h_beef);
    wait_tunes(2, 6);
    `CHK(tunes[tunes.size() - 1], 8'h_21)
    `CHK({use_host_cal, oscillator_count_value}, 17'h_1_beef)
    host.wr(OFS_CMD_STOP, 32'h_0000_0000);
    repeat (2) @(posedge ref_clk);
    `CHK(rx_active, 1'b0)
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict();
  end
endmodule : testbench
